/* File: rtl/grf_defs.vh */
`ifndef GRF_DEFS_VH
`define GRF_DEFS_VH

// operand sizes
`define GRF_SZ_BYTE 2'h0
`define GRF_SZ_WORD 2'h1
`define GRF_SZ_DWORD 2'h2
`define GRF_SZ_QWORD 2'h3

// processor operating modes
`define GRF_MODE_64 2'h0
`define GRF_MODE_COMPAT 2'h1
`define GRF_MODE_LEGACY 2'h2
`define GRF_MODE_REAL 2'h3

// segment register indices
`define GRF_SEG_EXTRA 3'h0
`define GRF_SEG_CODE 3'h1
`define GRF_SEG_STACK 3'h2
`define GRF_SEG_DATA 3'h3
`define GRF_SEG_AUX_F 3'h4
`define GRF_SEG_AUX_G 3'h5
`define GRF_NUM_SEG 6

// general registers
`define GRF_NUM_GPR 16
`define GRF_FIRST_EXT 8
`define GRF_GPR_RST 64'h0000000000000000

// segment reset values and selector fields
`define GRF_SEL_RST 16'h0000
`define GRF_BASE_RST 64'h0000000000000000
`define GRF_LIMIT_RST 32'h0000FFFF
`define GRF_SEL_INDEX_MSB 15
`define GRF_SEL_INDEX_LSB 2
`define GRF_SEL_INDEX_NULL 14'h0000

`endif

/* File: rtl/grf_seg_slot.v */
`include "grf_defs.vh"

// one segment register: selector plus the cached base and limit
module grf_seg_slot (
    input wire mclk_i,
    input wire reset_i,
    input wire load_i,
    input wire [15:0] sel_i,
    input wire [63:0] base_i,
    input wire [31:0] limit_i,
    output reg [15:0] sel_o,
    output reg [63:0] base_o,
    output reg [31:0] limit_o
);

    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            sel_o <= `GRF_SEL_RST;
            base_o <= `GRF_BASE_RST;
            limit_o <= `GRF_LIMIT_RST;
        end
        else if (load_i)
        begin
            sel_o <= sel_i;
            base_o <= base_i;
            limit_o <= limit_i;
        end
    end

endmodule // grf_seg_slot

/* File: rtl/grf_regfile.v */
// Notes on behaviour
// - 64-bit mode has sixteen general registers; operand size defaults to 32 bits.
// - every general register is accessible as byte, word, doubleword or quadword.
// - 64-bit size and registers eight to fifteen need the extension prefix.
// - extended registers survive a trip from 64-bit mode to compatibility and back.
// - a trip through legacy or real mode may lose the extended registers.
// - with the prefix, high-byte selectors address stack, frame, source, dest low bytes.
// - one instruction never mixes legacy high bytes with new byte registers.
// - a 64-bit write replaces all 64 bits of the destination.
// - a 32-bit write stores the result and zeroes the upper 32 bits.
// - 8-bit and 16-bit writes leave the upper 56 or 48 bits untouched.
// - upper 32 bits need not survive a switch from 64-bit to 32-bit mode.
// - six segment registers: code, stack, four data; each a 16-bit selector.
// - code segment rejects explicit loads; only control transfers write it.
// - fetch address is code segment combined with the instruction pointer.
// - stack accesses use the stack segment, which accepts explicit loads.
// - in 64-bit mode code, stack and first two data segments use base 0.
// - in 64-bit mode the two auxiliary segments still add their base.
// - segment loads in 64-bit mode still get the legacy validity checks.
// - in 64-bit mode no segment limit is checked.
// - an auxiliary base is added in full 64 bits, never truncated.
`include "grf_defs.vh"

module grf_regfile (
    input wire mclk_i,
    input wire reset_i,
    input wire [1:0] mode_i,
    input wire op_rex_i,
    input wire op_rexw_i,
    input wire [1:0] op_size_i,
    input wire [3:0] rd_a_sel_i,
    input wire [3:0] rd_b_sel_i,
    input wire wr_en_i,
    input wire [3:0] wr_sel_i,
    input wire [63:0] wr_data_i,
    input wire seg_ld_i,
    input wire seg_ld_implicit_i,
    input wire [2:0] seg_ld_idx_i,
    input wire [15:0] seg_ld_sel_i,
    input wire [63:0] seg_ld_base_i,
    input wire [31:0] seg_ld_limit_i,
    input wire [2:0] seg_rd_idx_i,
    input wire agen_en_i,
    input wire agen_stack_i,
    input wire [2:0] agen_seg_i,
    input wire [63:0] agen_off_i,
    input wire [63:0] fetch_ip_i,
    output reg [63:0] rd_a_data_o,
    output reg [63:0] rd_b_data_o,
    output reg [1:0] eff_size_o,
    output reg sel_err_o,
    output reg ext_lost_o,
    output reg seg_fault_o,
    output reg [15:0] seg_rd_sel_o,
    output reg [63:0] lin_addr_o,
    output reg limit_fault_o,
    output reg [15:0] fetch_cs_sel_o,
    output reg [63:0] fetch_addr_o
);

    reg [63:0] gpr_ff [0:`GRF_NUM_GPR-1];
    reg [1:0] mode_ff;
    reg lost_path_ff;
    wire mode64 = (mode_i == `GRF_MODE_64);
    // the prefix only exists in 64-bit mode
    wire rex_eff = op_rex_i & mode64;
    reg [1:0] eff_sz;

    wire [15:0] seg_sel [0:`GRF_NUM_SEG-1];
    wire [63:0] seg_base [0:`GRF_NUM_SEG-1];
    wire [31:0] seg_limit [0:`GRF_NUM_SEG-1];
    reg [`GRF_NUM_SEG-1:0] seg_load;

    // size resolution: byte and word as asked, quadword only with the prefix and W
    always @*
    begin
        if (op_size_i == `GRF_SZ_BYTE || op_size_i == `GRF_SZ_WORD)
            eff_sz = op_size_i;
        else if (rex_eff && op_rexw_i)
            eff_sz = `GRF_SZ_QWORD;
        else
            eff_sz = `GRF_SZ_DWORD;
    end

    // selectors 4..7 at byte size without the prefix name a legacy high byte;
    // with the prefix they name the low byte of the register itself, so the
    // two kinds can never meet inside one instruction
    function is_high_byte;
        input [3:0] sel;
        input [1:0] sz;
        input register_extension_prefix;
        begin
            is_high_byte = (sz == `GRF_SZ_BYTE) && !register_extension_prefix && sel[2] && !sel[3];
        end
    endfunction

    function [3:0] reg_index;
        input [3:0] sel;
        input [1:0] sz;
        input register_extension_prefix;
        begin
            if (is_high_byte(sel, sz, register_extension_prefix))
                reg_index = {2'h0, sel[1:0]};
            else if (register_extension_prefix)
                reg_index = sel;
            else
                reg_index = {1'b0, sel[2:0]};
        end
    endfunction

    function [63:0] narrow_read;
        input [63:0] val;
        input [1:0] sz;
        input hi;
        begin
            case (sz)
                `GRF_SZ_BYTE: narrow_read = hi ? {56'h0, val[15:8]} : {56'h0, val[7:0]};
                `GRF_SZ_WORD: narrow_read = {48'h0, val[15:0]};
                `GRF_SZ_DWORD: narrow_read = {32'h0, val[31:0]};
                default: narrow_read = val;
            endcase
        end
    endfunction

    function [63:0] merge_write;
        input [63:0] old;
        input [63:0] data;
        input [1:0] sz;
        input hi;
        begin
            case (sz)
                `GRF_SZ_BYTE:
                    merge_write = hi ? {old[63:16], data[7:0], old[7:0]}
                                     : {old[63:8], data[7:0]};
                `GRF_SZ_WORD: merge_write = {old[63:16], data[15:0]};
                `GRF_SZ_DWORD: merge_write = {32'h0, data[31:0]};
                default: merge_write = data;
            endcase
        end
    endfunction

    wire [3:0] rd_a_idx = reg_index(rd_a_sel_i, eff_sz, rex_eff);
    wire [3:0] rd_b_idx = reg_index(rd_b_sel_i, eff_sz, rex_eff);
    wire [3:0] wr_idx = reg_index(wr_sel_i, eff_sz, rex_eff);
    wire rd_a_hi = is_high_byte(rd_a_sel_i, eff_sz, rex_eff);
    wire rd_b_hi = is_high_byte(rd_b_sel_i, eff_sz, rex_eff);
    wire wr_hi = is_high_byte(wr_sel_i, eff_sz, rex_eff);
    // an extended register named without the prefix is refused
    wire wr_bad = wr_en_i && wr_sel_i[3] && !rex_eff;
    wire any_bad = wr_bad || ((rd_a_sel_i[3] || rd_b_sel_i[3]) && !rex_eff);

    // mode path tracking: compat round trips keep state, a visit to legacy
    // or real mode marks the extended registers as lost for the next return
    wire enter64 = mode64 && (mode_ff != `GRF_MODE_64);
    wire via_legacy = (mode_i == `GRF_MODE_LEGACY) || (mode_i == `GRF_MODE_REAL);
    wire wipe_ext = enter64 && lost_path_ff;

    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            mode_ff <= `GRF_MODE_REAL;
            lost_path_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= mode_i;
            if (enter64)
                lost_path_ff <= 1'b0;
            else if (via_legacy)
                lost_path_ff <= 1'b1;
        end
    end

    // upper halves are simply kept on a 64-to-32 switch; keeping them is
    // allowed and costs nothing, software may not rely on it
    integer i;
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            for (i = 0; i < `GRF_NUM_GPR; i = i + 1)
                gpr_ff[i] <= `GRF_GPR_RST;
        end
        else
        begin
            for (i = `GRF_FIRST_EXT; i < `GRF_NUM_GPR; i = i + 1)
                if (wipe_ext)
                    gpr_ff[i] <= `GRF_GPR_RST;
            // a write in the same cycle lands after the wipe, so it is kept
            if (wr_en_i && !wr_bad)
                gpr_ff[wr_idx] <= merge_write(gpr_ff[wr_idx], wr_data_i, eff_sz, wr_hi);
        end
    end

    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            rd_a_data_o <= `GRF_GPR_RST;
            rd_b_data_o <= `GRF_GPR_RST;
            eff_size_o <= `GRF_SZ_DWORD;
            sel_err_o <= 1'b0;
            ext_lost_o <= 1'b0;
        end
        else
        begin
            rd_a_data_o <= narrow_read(gpr_ff[rd_a_idx], eff_sz, rd_a_hi);
            rd_b_data_o <= narrow_read(gpr_ff[rd_b_idx], eff_sz, rd_b_hi);
            eff_size_o <= eff_sz;
            sel_err_o <= any_bad;
            // tells the vector file its upper registers are lost as well
            ext_lost_o <= wipe_ext;
        end
    end

    // segment register loads with their validity checks
    wire ld_idx_ok = (seg_ld_idx_i <= `GRF_SEG_AUX_G);
    wire ld_null = (seg_ld_sel_i[`GRF_SEL_INDEX_MSB:`GRF_SEL_INDEX_LSB] == `GRF_SEL_INDEX_NULL);
    wire ld_cs_explicit = (seg_ld_idx_i == `GRF_SEG_CODE) && !seg_ld_implicit_i;
    // checks run whatever the mode, so a selector loaded in 64-bit mode
    // remains valid when compatibility code picks it up
    wire ld_ss_null = (seg_ld_idx_i == `GRF_SEG_STACK) && ld_null && !seg_ld_implicit_i;
    wire ld_reject = !ld_idx_ok || ld_cs_explicit || ld_ss_null;

    always @*
    begin
        seg_load = {`GRF_NUM_SEG{1'b0}};
        if (seg_ld_i && !ld_reject)
            seg_load[seg_ld_idx_i] = 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < `GRF_NUM_SEG; g = g + 1)
        begin : seg_gen
            grf_seg_slot u_slot (
                .mclk_i(mclk_i),
                .reset_i(reset_i),
                .load_i(seg_load[g]),
                .sel_i(seg_ld_sel_i),
                .base_i(seg_ld_base_i),
                .limit_i(seg_ld_limit_i),
                .sel_o(seg_sel[g]),
                .base_o(seg_base[g]),
                .limit_o(seg_limit[g])
            );
        end
    endgenerate

    // address generation
    wire [2:0] ag_seg = agen_stack_i ? `GRF_SEG_STACK : agen_seg_i;
    wire ag_seg_ok = (ag_seg <= `GRF_SEG_AUX_G);
    wire [2:0] ag_idx = ag_seg_ok ? ag_seg : `GRF_SEG_DATA;
    wire ag_aux = (ag_idx == `GRF_SEG_AUX_F) || (ag_idx == `GRF_SEG_AUX_G);
    reg [63:0] ag_base;
    reg [63:0] ag_off;
    reg ag_over;

    always @*
    begin
        if (mode64)
        begin
            // flat space except the two auxiliary bases, added at full width
            ag_base = ag_aux ? seg_base[ag_idx] : `GRF_BASE_RST;
            ag_off = agen_off_i;
            ag_over = 1'b0;
        end
        else
        begin
            ag_base = seg_base[ag_idx];
            ag_off = {32'h0, agen_off_i[31:0]};
            ag_over = (agen_off_i[31:0] > seg_limit[ag_idx]);
        end
    end

    // fetch address: code base is zero in 64-bit mode
    wire [63:0] cs_base_eff = mode64 ? `GRF_BASE_RST : seg_base[`GRF_SEG_CODE];
    wire [63:0] ip_eff = mode64 ? fetch_ip_i : {32'h0, fetch_ip_i[31:0]};

    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            seg_fault_o <= 1'b0;
            seg_rd_sel_o <= `GRF_SEL_RST;
            lin_addr_o <= `GRF_BASE_RST;
            limit_fault_o <= 1'b0;
            fetch_cs_sel_o <= `GRF_SEL_RST;
            fetch_addr_o <= `GRF_BASE_RST;
        end
        else
        begin
            seg_fault_o <= seg_ld_i && ld_reject;
            seg_rd_sel_o <= (seg_rd_idx_i <= `GRF_SEG_AUX_G) ? seg_sel[seg_rd_idx_i]
                                                             : `GRF_SEL_RST;
            if (agen_en_i)
            begin
                lin_addr_o <= ag_base + ag_off;
                limit_fault_o <= ag_over || !ag_seg_ok;
            end
            else
            begin
                limit_fault_o <= 1'b0;
            end
            fetch_cs_sel_o <= seg_sel[`GRF_SEG_CODE];
            fetch_addr_o <= cs_base_eff + ip_eff;
        end
    end

endmodule // grf_regfile

/* File: sim/grf_checker.sv */
module grf_checker (
    input wire mclk_i,
    input wire reset_i,
    input wire [1:0] mode_i,
    input wire op_rex_i,
    input wire op_rexw_i,
    input wire [1:0] op_size_i,
    input wire wr_en_i,
    input wire [3:0] wr_sel_i,
    input wire seg_ld_i,
    input wire seg_ld_implicit_i,
    input wire [2:0] seg_ld_idx_i,
    input wire [15:0] seg_ld_sel_i,
    input wire agen_en_i,
    input wire [2:0] agen_seg_i,
    input wire [63:0] agen_off_i,
    input wire [63:0] fetch_ip_i,
    input wire [1:0] eff_size_o,
    input wire sel_err_o,
    input wire seg_fault_o,
    input wire [63:0] lin_addr_o,
    input wire limit_fault_o,
    input wire [63:0] fetch_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    AST_DWORD_DEFAULT: assert property (op_size_i == 2'h2 && !op_rexw_i |=>
        eff_size_o == 2'h2)
        else $error("dword default size lost");
    AST_QWORD_PREFIX: assert property (eff_size_o == 2'h3 |->
        $past(mode_i) == 2'h0 && $past(op_rex_i) && $past(op_rexw_i))
        else $error("quad size without prefix");
    AST_EXT_REFUSED: assert property (wr_en_i && wr_sel_i[3] &&
        !(mode_i == 2'h0 && op_rex_i) |=> sel_err_o)
        else $error("extended register reached without prefix");
    AST_CODE_REJECT: assert property (seg_ld_i && seg_ld_idx_i == 3'h1 &&
        !seg_ld_implicit_i |=> seg_fault_o)
        else $error("explicit code segment load accepted");
    AST_STACK_LOAD: assert property (seg_ld_i && seg_ld_idx_i == 3'h2
        && seg_ld_sel_i[15:2] != 14'h0 |=> !seg_fault_o)
        else $error("stack segment load refused");
    AST_FLAT_BASE: assert property (agen_en_i && mode_i == 2'h0 && agen_seg_i < 3'h4 |=>
        lin_addr_o == $past(agen_off_i))
        else $error("flat segment base not zero");
    AST_NO_LIMIT: assert property (agen_en_i && mode_i == 2'h0 && agen_seg_i < 3'h6 |=>
        !limit_fault_o)
        else $error("limit checked in 64-bit mode");
    AST_FETCH_FLAT: assert property (mode_i == 2'h0 ##1 mode_i == 2'h0 |->
        fetch_addr_o == $past(fetch_ip_i))
        else $error("fetch address not the pointer");
endmodule // grf_checker
bind grf_regfile grf_checker grf_checker_i (.*);

/* File: sim/grf_dp_model.sv */
module grf_dp_model (
    input wire logic mclk_i,
    input wire logic [63:0] rd_data_i,
    output logic wr_en_o,
    output logic [3:0] sel_o,
    output logic [63:0] wr_data_o,
    output logic [1:0] size_o,
    output logic rex_o,
    output logic rexw_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {wr_en_o, sel_o, wr_data_o, rex_o, rexw_o} = '0;
        size_o = 2'h2;
    end
    // one instruction per call: the prefix qualifies read and write alike
    task automatic op(input logic [3:0] s, input logic [1:0] z, input logic x, w, we,
        input logic [63:0] d, output logic [63:0] q);
        @(negedge mclk_i);
        {wr_en_o, sel_o, size_o, rex_o, rexw_o, wr_data_o} = {we, s, z, x, w, d};
        @(negedge mclk_i);
        q = rd_data_i;
        wr_en_o = 1'b0;
        wr_data_o = ~d; // a released bus must not keep the last value
    endtask
endmodule // grf_dp_model

/* File: sim/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i, reset_i, op_rex_i, op_rexw_i, wr_en_i, seg_ld_i, seg_ld_implicit_i;
    logic agen_en_i, agen_stack_i, sel_err_o, ext_lost_o, seg_fault_o, limit_fault_o, f, w;
    logic [1:0] mode_i, op_size_i, eff_size_o, sz;
    logic [2:0] seg_ld_idx_i, seg_rd_idx_i, agen_seg_i;
    logic [3:0] rd_a_sel_i, rd_b_sel_i, wr_sel_i, r;
    logic [15:0] seg_ld_sel_i, seg_rd_sel_o, fetch_cs_sel_o;
    logic [31:0] seg_ld_limit_i;
    logic [63:0] wr_data_i, seg_ld_base_i, agen_off_i, fetch_ip_i, rd_a_data_o, rd_b_data_o;
    logic [63:0] lin_addr_o, fetch_addr_o, pre, d, q, off;
    logic [63:0] sb [8];
    logic [23:0] tbl [9] = '{24'h100008, 24'h110010, 24'h200003, 24'h20001B, 24'h610030,
        24'h000040, 24'h300048, 24'h400050, 24'h500058};
    int err_count, checked, i;
    assign rd_a_sel_i = wr_sel_i;
    grf_regfile grf_regfile_i (.*);
    grf_dp_model grf_dp_model_i (.mclk_i(mclk_i), .rd_data_i(rd_a_data_o), .wr_en_o(wr_en_i),
        .sel_o(wr_sel_i), .wr_data_o(wr_data_i), .size_o(op_size_i), .rex_o(op_rex_i),
        .rexw_o(op_rexw_i));
    function automatic logic [63:0] exp_rd(input logic [63:0] v, input logic [1:0] s,
        input logic hi, qw);
        if (qw) return v;
        if (s[1]) return {32'h0, v[31:0]};
        if (s[0]) return {48'h0, v[15:0]};
        return {56'h0, hi ? v[15:8] : v[7:0]};
    endfunction
    function automatic logic [63:0] exp_wr(input logic [63:0] v, e, input logic [1:0] s,
        input logic hi, qw);
        if (qw) return e;
        if (s[1]) return {32'h0, e[31:0]};
        if (s[0]) return {v[63:16], e[15:0]};
        return hi ? {v[63:16], e[7:0], v[7:0]} : {v[63:8], e[7:0]};
    endfunction
    task automatic chk(input string n, input logic [63:0] e, g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic setm(input logic [1:0] m);
        @(negedge mclk_i);
        mode_i = m;
        repeat (2) @(negedge mclk_i);
    endtask
    task automatic seg(input logic [2:0] x, input logic im, input logic [15:0] s);
        @(negedge mclk_i);
        {seg_ld_i, seg_ld_implicit_i, seg_ld_idx_i, seg_rd_idx_i} = {1'b1, im, x, x};
        seg_ld_sel_i = s;
        {seg_ld_base_i, seg_ld_limit_i} = {d, 32'h00001000};
        @(negedge mclk_i);
        seg_ld_i = 1'b0;
    endtask
    task automatic ag(input logic [2:0] x, input logic [63:0] o);
        @(negedge mclk_i);
        {agen_en_i, agen_seg_i, agen_off_i} = {1'b1, x, o};
        @(negedge mclk_i);
        agen_en_i = 1'b0;
    endtask
    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        $display("wrong value run length expected end seen timeout");
        summarize();
    end
    initial
    begin
        {reset_i, mode_i, seg_ld_i, seg_ld_implicit_i, agen_en_i, agen_stack_i} = {1'b1, 6'h0};
        {seg_ld_idx_i, seg_rd_idx_i, agen_seg_i, rd_b_sel_i, seg_ld_sel_i} = '0;
        {seg_ld_limit_i, seg_ld_base_i, agen_off_i, fetch_ip_i} = '0;
        {err_count, checked} = '0;
        void'($urandom(32'hBE11));
        repeat (16) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_i = 1'b0;
        grf_dp_model_i.op(4'h0, 2'h3, 1'b1, 1'b1, 1'b0, 64'h0, q);
        chk("gpr after reset", 64'h0, q);
        for (i = 0; i < 12; i++)
        begin
            sz = i[1:0];
            w = (sz == 2'h3) && (i < 8); // last quad request lacks W: falls back to dword
            r = 4'($urandom_range(15));
            rd_b_sel_i = r;
            {pre, d} = {$urandom, $urandom, $urandom, $urandom};
            grf_dp_model_i.op(r, 2'h3, 1'b1, 1'b1, 1'b1, pre, q);
            grf_dp_model_i.op(r, sz, 1'b1, w, 1'b1, d, q);
            chk("narrow read", exp_rd(pre, sz, 1'b0, w), q);
            chk("narrow read b", exp_rd(pre, sz, 1'b0, w), rd_b_data_o);
            grf_dp_model_i.op(r, 2'h3, 1'b1, 1'b1, 1'b0, d, q);
            chk("merged write", exp_wr(pre, d, sz, 1'b0, w), q);
        end
        for (i = 0; i < 2; i++)
        begin
            {pre, d} = {$urandom, $urandom, $urandom, $urandom};
            grf_dp_model_i.op(4'(i * 4), 2'h3, 1'b1, 1'b1, 1'b1, pre, q);
            grf_dp_model_i.op(4'h4, 2'h0, i[0], 1'b0, 1'b1, d, q);
            chk("byte sel read", exp_rd(pre, 2'h0, !i[0], 1'b0), q);
            grf_dp_model_i.op(4'(i * 4), 2'h3, 1'b1, 1'b1, 1'b0, d, q);
            chk("byte sel write", exp_wr(pre, d, 2'h0, !i[0], 1'b0), q);
        end
        pre = {$urandom, $urandom};
        grf_dp_model_i.op(4'h9, 2'h3, 1'b1, 1'b1, 1'b1, pre, q);
        grf_dp_model_i.op(4'h9, 2'h2, 1'b0, 1'b0, 1'b1, ~pre, q);
        chk("ext sel refused", 64'h1, {63'h0, sel_err_o});
        setm(2'h1);
        setm(2'h0);
        grf_dp_model_i.op(4'h9, 2'h3, 1'b1, 1'b1, 1'b0, pre, q);
        chk("ext kept", pre, q);
        setm(2'h1);
        setm(2'h2);
        setm(2'h3);
        setm(2'h1);
        @(negedge mclk_i);
        mode_i = 2'h0;
        @(negedge mclk_i);
        chk("ext lost", 64'h1, {63'h0, ext_lost_o});
        @(negedge mclk_i);
        grf_dp_model_i.op(4'h9, 2'h3, 1'b1, 1'b1, 1'b0, pre, q);
        chk("ext after legacy", 64'h0, q);
        for (i = 0; i < 9; i++)
        begin
            d = {$urandom, $urandom};
            seg(tbl[i][22:20], tbl[i][16], tbl[i][15:0]);
            f = tbl[i][22:20] > 3'h5 || (tbl[i][22:20] == 3'h1 && !tbl[i][16]) ||
                (tbl[i][22:20] == 3'h2 && !tbl[i][16] && tbl[i][15:2] == 14'h0);
            chk("seg fault", {63'h0, f}, {63'h0, seg_fault_o});
            if (!f) sb[tbl[i][22:20]] = d;
            @(negedge mclk_i);
            if (!f) chk("seg sel", {48'h0, tbl[i][15:0]}, {48'h0, seg_rd_sel_o});
        end
        for (i = 0; i < 7; i++)
        begin
            off = {$urandom, $urandom};
            agen_stack_i = (i == 6); // forced stack through an aux index
            ag((i == 6) ? 3'h4 : 3'(i), off);
            pre = (i == 4 || i == 5) ? sb[i] + off : off;
            chk("lin 64", pre, lin_addr_o);
            chk("no limit 64", 64'h0, {63'h0, limit_fault_o});
        end
        agen_stack_i = 1'b0;
        setm(2'h1);
        for (i = 0; i < 2; i++)
        begin
            off = {$urandom, 32'(32'h00001000 + i)};
            ag(3'h3, off);
            chk("lin 32", sb[3] + {32'h0, off[31:0]}, lin_addr_o);
            chk("limit 32", 64'(i), {63'h0, limit_fault_o});
        end
        fetch_ip_i = {$urandom, $urandom};
        repeat (2) @(negedge mclk_i);
        chk("fetch 32", sb[1] + {32'h0, fetch_ip_i[31:0]}, fetch_addr_o);
        chk("fetch sel", 64'h10, {48'h0, fetch_cs_sel_o});
        setm(2'h0);
        chk("fetch 64", fetch_ip_i, fetch_addr_o);
        summarize();
    end
endmodule // tb
